/* hw/crc_pkg.sv */
// Package for the cable reflectometry configuration and sequencing block
package crc_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CFG_A = 10'h180;
  localparam logic [9:0] IDX_CFG_B = 10'h181;
  localparam logic [9:0] IDX_SEG_A = 10'h182;
  localparam logic [9:0] IDX_SEG_B = 10'h183;
  localparam logic [9:0] IDX_CTRL = 10'h18f;
  localparam int ADDR_W = 12;
  // ---------------------------------------------------------------
  // Reset values and read masks
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CFG_A = 16'h0752;
  localparam logic [15:0] RST_CFG_B = 16'hc850;
  localparam logic [15:0] RST_SEG_A = 16'h5326;
  localparam logic [15:0] RST_SEG_B = 16'ha01e;
  localparam logic [15:0] MASK_CFG_B = 16'hfff0;
  localparam logic [15:0] MASK_SEG_A = 16'h7fff;
  localparam logic [15:0] MASK_SEG_B = 16'hff3f;
  // Control/status bit positions
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_NLP = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int QUIET_UNIT_US = 1;
  localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
  localparam int NUM_SEGS = 5;
  localparam int LAST_PAIR_ALL = 3;
  localparam int LAST_PAIR_AB = 1;
  localparam logic [2:0] AVG_RESERVED = 3'h7;
  localparam logic [2:0] AVG_MAX_CODE = 3'h6;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] spare;
    logic pairCdSkip;
    logic crossListenDisable;
    logic linkPulseCheckInSilence;
    logic [2:0] averagingCountCode;
    logic [2:0] segmentCount;
    logic [3:0] cycleLength;
  } crc_cfg_a_type;
  typedef struct packed {
    logic [7:0] silenceThreshold;
    logic [1:0] postMeasureQuietWindow;
    logic [1:0] preMeasureQuietWindow;
    logic [3:0] spare;
  } crc_cfg_b_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_MEAS = 4'b0100,
    ST_POST = 4'b1000
  } crc_state_type;
endpackage

/* hw/crc_cable_reflectometry_config.sv */
// Reflectometry configuration registers and measurement sequencer with APB access
`timescale 1ns/100ps
`default_nettype none
module crc_cable_reflectometry_config import crc_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineEnergy,
  input wire logic linkPulse,
  output logic [3:0] txPair,
  output logic [3:0] rxPair,
  output logic [2:0] segActive,
  output logic silenceActive,
  output logic testBusy
);
  // ---------------------------------------------------------------
  // Registers and bus decode
  // ---------------------------------------------------------------
  crc_cfg_a_type cfgA;
  crc_cfg_b_type cfgB;
  logic [15:0] segA, segB;
  logic doneFlag, failFlag, nlpSeen;
  crc_state_type state;
  logic [9:0] idx;
  logic busWrite, startReq, hit;
  logic [15:0] rdVal;
  assign idx = paddr[ADDR_W-1:2];
  assign busWrite = psel && penable && pready && pwrite;
  assign startReq = busWrite && idx == IDX_CTRL && pwdata[CTRL_START] && state == ST_IDLE;
  // Read mux and decode
  always_comb begin
    hit = 1'b1;
    rdVal = 16'h0000;
    unique case (idx)
      IDX_CFG_A: rdVal = cfgA;
      IDX_CFG_B: rdVal = cfgB & MASK_CFG_B;
      IDX_SEG_A: rdVal = segA & MASK_SEG_A;
      IDX_SEG_B: rdVal = segB & MASK_SEG_B;
      IDX_CTRL: rdVal = {12'h000, nlpSeen, failFlag, doneFlag, state != ST_IDLE};
      default: hit = 1'b0;
    endcase
  end
  // APB answer: one wait state, registered
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready) begin
        prdata <= (hit && !pwrite) ? {16'h0000, rdVal} : 32'h0000_0000;
      end
    end
  end
  // Configuration writes
  always_ff @(posedge clock) begin
    if (srst) begin
      cfgA <= RST_CFG_A;
      cfgB <= RST_CFG_B;
      segA <= RST_SEG_A;
      segB <= RST_SEG_B;
    end else if (busWrite) begin
      if (idx == IDX_CFG_A) cfgA <= pwdata[15:0];
      if (idx == IDX_CFG_B) cfgB <= pwdata[15:0] & MASK_CFG_B;
      if (idx == IDX_SEG_A) segA <= pwdata[15:0] & MASK_SEG_A;
      if (idx == IDX_SEG_B) segB <= pwdata[15:0] & MASK_SEG_B;
    end
  end
  // ---------------------------------------------------------------
  // Line input synchronisers
  // ---------------------------------------------------------------
  logic energyMeta, energySync, pulseMeta, pulseSync;
  always_ff @(posedge clock) begin
    if (srst) begin
      energyMeta <= 1'b0;
      energySync <= 1'b0;
      pulseMeta <= 1'b0;
      pulseSync <= 1'b0;
    end else begin
      energyMeta <= lineEnergy;
      energySync <= energyMeta;
      pulseMeta <= linkPulse;
      pulseSync <= pulseMeta;
    end
  end
  // ---------------------------------------------------------------
  // Derived settings
  // ---------------------------------------------------------------
  logic [2:0] avgCode;
  logic [6:0] avgLastIdx;
  logic [3:0] cycLen;
  logic [1:0] lastPair;
  logic [8:0] segLen;
  logic [3:0] quietUs;
  logic quiet;
  assign avgCode = (cfgA.averagingCountCode == AVG_RESERVED) ? AVG_MAX_CODE
                                                             : cfgA.averagingCountCode;
  assign avgLastIdx = 7'((8'h01 << avgCode) - 8'h01);
  assign cycLen = (cfgA.cycleLength == 4'h0) ? 4'h1 : cfgA.cycleLength;
  assign lastPair = cfgA.pairCdSkip ? 2'(LAST_PAIR_AB) : 2'(LAST_PAIR_ALL);
  assign quiet = state == ST_PRE || state == ST_POST;
  assign quietUs = 4'(QUIET_UNIT_US) * (state == ST_PRE ? {2'b00, cfgB.preMeasureQuietWindow}
                                                      : {2'b00, cfgB.postMeasureQuietWindow}) + 4'(QUIET_UNIT_US);
  // Per-segment length in 125 MHz ticks
  logic [2:0] segIdx;
  always_comb begin
    segLen = {1'b0, segB[15:8]};
    unique case (segIdx)
      3'h0: segLen = {4'h0, segA[4:0]};
      3'h1: segLen = {4'h0, segA[9:5]};
      3'h2: segLen = {4'h0, segA[14:10]};
      3'h3: segLen = {3'h0, segB[5:0]};
      default: segLen = {1'b0, segB[15:8]};
    endcase
  end
  // ---------------------------------------------------------------
  // Timebase: microsecond tick and 125 MHz tick phase
  // ---------------------------------------------------------------
  logic [6:0] usDiv;
  logic usTick, phaseStart;
  logic [1:0] phase;
  logic [3:0] usCnt;
  assign usTick = usDiv == US_LAST;
  always_ff @(posedge clock) begin
    if (srst || phaseStart) begin
      usDiv <= 7'h00;
      phase <= 2'h0;
    end else begin
      usDiv <= usTick ? 7'h00 : usDiv + 7'h01;
      phase <= phase + 2'h1;
    end
  end
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [1:0] pairIdx;
  logic [6:0] avgIdx;
  logic [8:0] segTicks;
  logic cycleEnd, segDone;
  assign cycleEnd = state == ST_MEAS && usTick && usCnt == cycLen - 4'h1;
  assign segDone = segIdx < cfgA.segmentCount && segTicks >= segLen;
  assign phaseStart = startReq || (quiet && usTick && usCnt == quietUs - 4'h1) || cycleEnd;
  // State and phase counters
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      usCnt <= 4'h0;
      pairIdx <= 2'h0;
      avgIdx <= 7'h00;
      segIdx <= 3'h0;
      segTicks <= 9'h000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          usCnt <= 4'h0;
          if (startReq) state <= ST_PRE;
        end
        ST_PRE, ST_POST: begin
          if (energySync) begin
            state <= ST_IDLE;
          end else if (usTick && usCnt == quietUs - 4'h1) begin
            usCnt <= 4'h0;
            state <= (state == ST_PRE) ? ST_MEAS : ST_IDLE;
            pairIdx <= 2'h0;
            avgIdx <= 7'h00;
            segIdx <= 3'h0;
            segTicks <= 9'h000;
          end else if (usTick) begin
            usCnt <= usCnt + 4'h1;
          end
        end
        ST_MEAS: begin
          // 125 MHz ticks: five per four clocks
          segTicks <= segDone ? 9'h000 : segTicks + ((phase == 2'h3) ? 9'h002 : 9'h001);
          if (segDone) segIdx <= segIdx + 3'h1;
          if (cycleEnd) begin
            usCnt <= 4'h0;
            segIdx <= 3'h0;
            segTicks <= 9'h000;
            if (avgIdx == avgLastIdx) begin
              avgIdx <= 7'h00;
              if (pairIdx == lastPair) begin
                state <= ST_POST;
              end else begin
                pairIdx <= pairIdx + 2'h1;
              end
            end else begin
              avgIdx <= avgIdx + 7'h01;
            end
          end else if (usTick) begin
            usCnt <= usCnt + 4'h1;
          end
        end
      endcase
    end
  end
  // Result flags: start clears, hardware events set
  always_ff @(posedge clock) begin
    if (srst) begin
      doneFlag <= 1'b0;
      failFlag <= 1'b0;
      nlpSeen <= 1'b0;
    end else begin
      if (startReq) begin
        doneFlag <= 1'b0;
        failFlag <= 1'b0;
        nlpSeen <= 1'b0;
      end
      if (quiet && energySync) begin
        failFlag <= 1'b1;
        doneFlag <= 1'b1;
      end
      if (state == ST_POST && usTick && usCnt == quietUs - 4'h1 && !energySync) doneFlag <= 1'b1;
      if (quiet && cfgA.linkPulseCheckInSilence && pulseSync) nlpSeen <= 1'b1;
    end
  end
  // Line-side outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      txPair <= 4'h0;
      rxPair <= 4'h0;
      segActive <= 3'h0;
      silenceActive <= 1'b0;
      testBusy <= 1'b0;
    end else begin
      txPair <= (state == ST_MEAS) ? 4'(4'h1 << pairIdx) : 4'h0;
      if (state != ST_MEAS) begin
        rxPair <= 4'h0;
      end else if (cfgA.crossListenDisable) begin
        rxPair <= 4'(4'h1 << pairIdx);
      end else begin
        rxPair <= cfgA.pairCdSkip ? 4'h3 : 4'hf;
      end
      segActive <= segIdx;
      silenceActive <= quiet && cfgA.linkPulseCheckInSilence;
      testBusy <= state != ST_IDLE;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_cd_skip: assert property (@(posedge clock) disable iff (srst)
    (state == ST_MEAS && cfgA.pairCdSkip && $stable(cfgA)) |=> txPair[3:2] == 2'b00)
    else $error("pair C or D driven while skipped");
  chk_rx_same: assert property (@(posedge clock) disable iff (srst)
    ($past(cfgA.crossListenDisable) && txPair != 4'h0) |-> rxPair == txPair)
    else $error("receive pair differs from driven pair");
  chk_nlp_flag: assert property (@(posedge clock) disable iff (srst)
    (quiet && cfgA.linkPulseCheckInSilence && pulseSync && !startReq) |=> nlpSeen)
    else $error("link pulse in quiet window not flagged");
  chk_avg_full: assert property (@(posedge clock) disable iff (srst)
    (state == ST_MEAS && $past(state) == ST_MEAS && $changed(pairIdx))
      |-> $past(avgIdx) == $past(avgLastIdx))
    else $error("pair advanced before averaging finished");
  chk_seg_limit: assert property (@(posedge clock) disable iff (srst)
    state == ST_MEAS |-> segIdx <= cfgA.segmentCount)
    else $error("segment index past segment count");
  chk_cycle_len: assert property (@(posedge clock) disable iff (srst)
    (state == ST_MEAS && $past(state) == ST_MEAS && $changed(avgIdx))
      |-> $past(usCnt) == $past(cycLen) - 4'h1 && $past(usDiv) == US_LAST)
    else $error("cycle ended at wrong time");
  chk_fail_energy: assert property (@(posedge clock) disable iff (srst)
    (quiet && energySync) |=> failFlag && doneFlag && state == ST_IDLE ##1 !testBusy)
    else $error("energy in quiet window did not fail the test");
  chk_seg_run: assert property (@(posedge clock) disable iff (srst)
    (state == ST_MEAS && $past(state) == ST_MEAS && segIdx == $past(segIdx) + 3'h1)
      |-> $past(segTicks) >= $past(segLen))
    else $error("segment ended before its tick count");
  chk_apb_wait: assert property (@(posedge clock) disable iff (srst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer not one wait state");
  cov_pass: cover property (@(posedge clock) disable iff (srst)
    state == ST_POST ##1 state == ST_IDLE && doneFlag && !failFlag);
  cov_fail: cover property (@(posedge clock) disable iff (srst)
    state == ST_PRE && energySync ##1 failFlag);
  cov_skip: cover property (@(posedge clock) disable iff (srst)
    state == ST_MEAS && cfgA.pairCdSkip && pairIdx == 2'h1);
endmodule
`default_nettype wire

/* tb/crc_cable_model.sv */
// Behavioural copper cable model: foreign line energy and periodic link pulses
`timescale 1ns/100ps
`default_nettype none
module crc_cable_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic energyOn,
  input wire logic pulseOn,
  output logic lineEnergy,
  output logic linkPulse
);
  logic [4:0] pulseTimer;
  // -------------------------------------------------------------
  // Line behaviour
  // -------------------------------------------------------------
  // Foreign energy from a live link partner while commanded
  always_ff @(posedge clock) begin
    lineEnergy <= srst ? 1'b0 : energyOn;
  end
  // One-cycle link pulse every 32 clocks while a partner is present
  always_ff @(posedge clock) begin
    if (srst) begin
      pulseTimer <= 5'h00;
      linkPulse <= 1'b0;
    end else begin
      pulseTimer <= pulseTimer + 5'h01;
      linkPulse <= pulseOn && (pulseTimer == 5'h00);
    end
  end
endmodule
`default_nettype wire

/* tb/crc_cable_reflectometry_config_tb.sv */
// Self-checking bench for the reflectometry configuration block
`timescale 1ns/100ps
`default_nettype none
module crc_cable_reflectometry_config_tb import crc_pkg::*;;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
  logic lineEnergy, linkPulse, energyOn, pulseOn, testBusy, silenceActive;
  logic crossDis, rxBad, sawQuiet, monClear;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] txPair, rxPair, txOr, rxAll;
  logic [2:0] segActive, maxSeg;
  int txCount, errCount, checksDone;
  crc_cable_reflectometry_config dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lineEnergy(lineEnergy), .linkPulse(linkPulse),
    .txPair(txPair), .rxPair(rxPair), .segActive(segActive),
    .silenceActive(silenceActive), .testBusy(testBusy));
  crc_cable_model cable (.clock(clock), .srst(srst), .energyOn(energyOn),
    .pulseOn(pulseOn), .lineEnergy(lineEnergy), .linkPulse(linkPulse));
  // -------------------------------------------------------------
  // Clock, watchdog and line monitor
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #600000;
    errCount++;
    $display("MISMATCH %0t watchdog expired", $time);
    reportAndStop();
  end
  // Gathers what the engine did on the pairs during one test
  always @(posedge clock) begin
    if (monClear) begin
      txCount <= 0;
      txOr <= 4'h0;
      rxBad <= 1'b0;
      sawQuiet <= 1'b0;
      maxSeg <= 3'h0;
    end else begin
      if (testBusy === 1'b1 && txPair !== 4'h0) begin
        txCount <= txCount + 1;
        txOr <= txOr | txPair;
        if (rxPair !== (crossDis ? txPair : rxAll)) rxBad <= 1'b1;
      end
      if (silenceActive === 1'b1) sawQuiet <= 1'b1;
      if (testBusy === 1'b1 && segActive > maxSeg) maxSeg <= segActive;
    end
  end
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apbXfer(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      errCount++;
      $display("MISMATCH %0t bus answer missing", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Configures, runs one test to the end and compares what was seen
  task automatic runTest(input logic [15:0] cfgA, input int expTx, input logic [3:0] expOr,
    input logic [2:0] expSeg, input logic expQuiet, input logic [31:0] expStat);
    int n;
    apbXfer(IDX_CFG_A, 1'b1, {16'h0000, cfgA});
    crossDis <= cfgA[11];
    rxAll <= cfgA[12] ? 4'h3 : 4'hf;
    // Monitor clears its tallies at the next edge
    monClear <= 1'b1;
    @(posedge clock);
    monClear <= 1'b0;
    apbXfer(IDX_CTRL, 1'b1, 32'h00000001);
    n = 0;
    while (testBusy !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    // A second start while running must be ignored
    if (expTx > 0) apbXfer(IDX_CTRL, 1'b1, 32'h00000001);
    n = 0;
    while (testBusy === 1'b1 && n < 30000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 30000) begin
      errCount++;
      $display("MISMATCH %0t test did not finish", $time);
    end
    apbXfer(IDX_CTRL, 1'b0, 32'h0);
    check(32'(txCount >= expTx - 2 && txCount <= expTx + 2), 32'h1);
    check({28'h0, txOr}, {28'h0, expOr});
    check({31'h0, rxBad}, 32'h0);
    check({29'h0, maxSeg}, {29'h0, expSeg});
    check({31'h0, sawQuiet}, {31'h0, expQuiet});
    check(rd, expStat);
  endtask
  task automatic reportAndStop();
    $display("errors %0d checks %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    energyOn = 1'b0;
    pulseOn = 1'b0;
    crossDis = 1'b0;
    rxAll = 4'hf;
    monClear = 1'b0;
    errCount = 0;
    checksDone = 0;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    apbXfer(IDX_CFG_A, 1'b0, 32'h0);
    check(rd, 32'h00000752);
    apbXfer(IDX_CFG_B, 1'b0, 32'h0);
    check(rd, 32'h0000c850);
    apbXfer(IDX_SEG_A, 1'b0, 32'h0);
    check(rd, 32'h00005326);
    apbXfer(IDX_SEG_B, 1'b0, 32'h0);
    check(rd, 32'h0000a01e);
    apbXfer(10'h000, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Shortest quiet windows; reserved low bits must read back zero
    apbXfer(IDX_CFG_B, 1'b1, 32'h0000c80f);
    apbXfer(IDX_CFG_B, 1'b0, 32'h0);
    check(rd, 32'h0000c800);
    // Energy before the measurement fails the test at once
    energyOn <= 1'b1;
    runTest(16'h0052, 0, 4'h0, 3'h0, 1'b0, 32'h00000006);
    energyOn <= 1'b0;
    pulseOn <= 1'b1;
    // All pairs, cross listening, no link-pulse watch; index ends at the count
    runTest(16'h0052, 800, 4'hf, 3'h5, 1'b0, 32'h00000002);
    // Pairs A and B only, own-pair listening, averaging codes 0 to 6
    for (int c = 0; c < 7; c++) begin
      runTest(16'h1c21 | 16'(c << 7), 200 << c, 4'h3, 3'h2, 1'b1, 32'h0000000a);
    end
    // Reserved averaging code runs as the longest; both kept pairs listened
    runTest(16'h17a1, 12800, 4'h3, 3'h2, 1'b1, 32'h0000000a);
    reportAndStop();
  end
endmodule
`default_nettype wire
